//--- common/whr_pkg.sv
// Purpose: shared constants and types for the watchdog, sleep and reset control block
// Assumes: one 200 MHz clock, APB register access, instruction pulses from the core
// Notes:   register offsets are byte addresses of aligned 32-bit words
//
// What this block does
// - watchdog ticks from instruction clock (system clock / 4) or 12kHz RC, by config.
// - watchdog period is source divided by two to the n, n from 8 to 11.
// - watchdog disabled means clear instructions do nothing and no watchdog reset.
// - watchdog overflow in normal running gives chip reset and sets timeout flag.
// - prescaler is cleared by the configured clear instructions or by sleep.
// - single-clear mode: every single clear clears; the clear pair is ignored.
// - dual-clear mode: watchdog clears only once both pair instructions have executed.
// - sleep stops the system oscillator; the RC source keeps running if selected.
// - during sleep memory, registers and port pins hold their state.
// - sleep sets power-down flag, clears timeout flag, clears the prescaler.
// - sleep ends on a falling edge at any wake-enabled port B pin.
// - port wake-up is no reset; execution continues after the sleep instruction.
// - 1024 system clock start-up delay at power-up and after every wake from sleep.
// - power-down flag clears at power-up and on each watchdog clear.
// - reset causes are power-on, external pin, low voltage and watchdog timeout.
// - flags per cause: power-on 00, pin/low voltage unchanged, watchdog 1u, sleep 01, watchdog in sleep 11.
// - chip reset loads program counter 000H, clears prescaler, inputs, stack at top.
// - chip reset drives carrier pin low or floats it, by pin type config.
// - timeout flag clears on power-up, watchdog clear or sleep; set by timeout.
// - status writes never change power-down (bit 4) or timeout (bit 5) flags.

package whr_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] ADDR_CONFIG  = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
    localparam logic [7:0] ADDR_STATE   = 8'h0C;

    // config fields
    localparam int CFG_WDT_EN_BIT = 0;
    localparam int CFG_SRC_RC_BIT = 1;
    localparam int CFG_N_LSB      = 2;
    localparam int CFG_DUAL_BIT   = 4;
    localparam int CFG_NMOS_BIT   = 5;

    // status fields
    localparam int STAT_PD_BIT = 4;
    localparam int STAT_TO_BIT = 5;

    // reset values: watchdog on, instruction clock, n = 8, single clear, cmos pin
    localparam logic [5:0] CFG_RESET     = 6'h01;
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;
    localparam logic [9:0] PC_RESET      = 10'h000;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
    localparam int unsigned RC_FREQ_HZ     = 12_000;
    localparam int unsigned RC_DIV_CYCLES  = CLK_FREQ_HZ / RC_FREQ_HZ;
    localparam int unsigned INSTR_DIV      = 4;
    localparam int unsigned STARTUP_CYCLES = 1024;
    localparam int unsigned WDT_N_MIN      = 8;
    localparam int unsigned WDT_CNT_W      = 11;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_STARTUP = 2'b01,
        ST_RUN     = 2'b10,
        ST_SLEEP   = 2'b11
    } whr_state_t;

    typedef struct packed {
        logic       carrier_nmos;
        logic       dual_clear;
        logic [1:0] wdt_n_sel;
        logic       src_rc;
        logic       wdt_en;
    } whr_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } whr_apb_req_t;

    typedef struct packed {
        logic clear_single;
        logic clear_first;
        logic clear_second;
        logic sleep;
    } whr_core_cmd_t;

endpackage

//--- hw/whr_tick_div.sv
// Purpose: clock-enable divider, one-cycle tick every DIV cycles while running
// Assumes: single clock domain
// Notes:   counter restarts from zero whenever run is low
`timescale 1ns/10ps
`default_nettype none

module whr_tick_div #(
    parameter int unsigned DIV = 4
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // control
    input  wire logic run_in,
    // tick
    output var  logic tick_out
);

    localparam logic [15:0] LAST = 16'(DIV - 1);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } whr_div_state_t;

    whr_div_state_t q;
    whr_div_state_t d;

    // count and emit one pulse per wrap
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (!run_in) begin
            d.cnt = 16'h0000;
        end else if (q.cnt == LAST) begin
            d.cnt  = 16'h0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;

endmodule // whr_tick_div

`default_nettype wire

//--- hw/whr_top.sv
// Purpose: watchdog, sleep / wake-up, start-up delay and reset merge with cause flags
// Assumes: clk_in is the system clock; rstn_in is the power-on reset; core
//          instruction strobes are one-cycle pulses synchronous to clk_in
// Notes:   configuration and flags survive pin, low-voltage and watchdog resets
`timescale 1ns/10ps
`default_nettype none

module whr_top #(
    parameter int unsigned RC_DIV_CYCLES = whr_pkg::RC_DIV_CYCLES
) (
    // clock and power-on reset
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    // apb slave
    input  wire whr_pkg::whr_apb_req_t apb_in,
    output var  logic                  pready_out,
    output var  logic [31:0]           prdata_out,
    output var  logic                  pslverr_out,
    // core instruction strobes
    input  wire whr_pkg::whr_core_cmd_t core_cmd_in,
    // reset sources
    input  wire logic                  external_reset_pin_n_in,
    input  wire logic                  low_voltage_reset_in,
    // wake port and carrier
    input  wire logic [7:0]            wake_port_in,
    input  wire logic                  carrier_in,
    // to the core and pads
    output var  logic                  chip_reset_out,
    output var  logic [9:0]            pc_reset_value_out,
    output var  logic                  core_run_out,
    output var  logic                  sys_osc_run_out,
    output var  logic                  io_hold_out,
    output var  logic                  io_input_mode_out,
    output var  logic                  carrier_pin_out,
    output var  logic                  carrier_pin_oe_out
);

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        whr_pkg::whr_state_t             state;
        logic                            from_reset;
        logic [9:0]                      start_cnt;
        logic [whr_pkg::WDT_CNT_W-1:0]   wdt_cnt;
        logic                            first_seen;
        logic                            second_seen;
        logic                            to_flag;
        logic                            pd_flag;
        logic [7:0]                      wake_prev;
        whr_pkg::whr_cfg_t               cfg;
        logic [7:0]                      wake_en;
        logic                            pready;
        logic [31:0]                     prdata;
        logic                            pslverr;
        logic                            chip_reset;
        logic                            core_run;
        logic                            osc_run;
        logic                            io_hold;
        logic                            io_input;
        logic                            carr_o;
        logic                            carr_oe;
    } whr_top_state_t;

    localparam logic [9:0] START_LAST = 10'(whr_pkg::STARTUP_CYCLES - 1);

    whr_top_state_t q;
    whr_top_state_t d;

    logic instr_tick;
    logic rc_tick;

    // ***************************************************************
    // clock sources
    // ***************************************************************
    // instruction clock only exists while the system oscillator runs
    whr_tick_div #(.DIV(whr_pkg::INSTR_DIV)) u_instr_div (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .run_in   (q.osc_run),
        .tick_out (instr_tick)
    );

    // rc oscillator is free running, independent of sleep
    whr_tick_div #(.DIV(RC_DIV_CYCLES)) u_rc_div (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .run_in   (1'b1),
        .tick_out (rc_tick)
    );

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        logic                          running;
        logic                          asleep;
        logic                          wdt_src_tick;
        logic [whr_pkg::WDT_CNT_W-1:0] limit;
        logic                          overflow;
        logic                          clr_single;
        logic                          clr_dual;
        logic                          wdt_clear;
        logic                          sleep_cmd;
        logic                          reset_src;
        logic                          wake;
        logic                          f_seen;
        logic                          s_seen;
        logic                          acc;
        logic                          addr_ok;
        logic [31:0]                   rdata;

        d            = q;
        running      = (q.state == whr_pkg::ST_RUN);
        asleep       = (q.state == whr_pkg::ST_SLEEP);
        wdt_src_tick = q.cfg.src_rc ? rc_tick : instr_tick;
        limit        = {whr_pkg::WDT_CNT_W{1'b1}} >> (2'd3 - q.cfg.wdt_n_sel);
        overflow     = q.cfg.wdt_en && (running || asleep) && wdt_src_tick
                       && (q.wdt_cnt == limit);
        reset_src    = !external_reset_pin_n_in || low_voltage_reset_in;

        // clear instructions; only the configured style is live
        clr_single = running && q.cfg.wdt_en && !q.cfg.dual_clear
                     && core_cmd_in.clear_single;
        f_seen     = q.first_seen || core_cmd_in.clear_first;
        s_seen     = q.second_seen || core_cmd_in.clear_second;
        clr_dual   = running && q.cfg.wdt_en && q.cfg.dual_clear
                     && f_seen && s_seen;
        wdt_clear  = clr_single || clr_dual;
        sleep_cmd  = running && core_cmd_in.sleep && !overflow;

        // pair bookkeeping; a lone half never clears anything
        if (running && q.cfg.wdt_en && q.cfg.dual_clear && !clr_dual) begin
            d.first_seen  = f_seen;
            d.second_seen = s_seen;
        end else begin
            d.first_seen  = 1'b0;
            d.second_seen = 1'b0;
        end

        // wake only from enabled pins, falling edge
        wake        = asleep && |(q.wake_prev & ~wake_port_in & q.wake_en);
        d.wake_prev = wake_port_in;

        // prescaler
        if (!(running || asleep) || wdt_clear || sleep_cmd || overflow) begin
            d.wdt_cnt = '0;
        end else if (q.cfg.wdt_en && wdt_src_tick) begin
            d.wdt_cnt = q.wdt_cnt + 11'h001;
        end

        // flags: clear first so a same-cycle set wins
        if (wdt_clear || sleep_cmd) begin
            d.to_flag = 1'b0;
        end
        if (overflow) begin
            d.to_flag = 1'b1;
        end
        if (wdt_clear) begin
            d.pd_flag = 1'b0;
        end
        if (sleep_cmd) begin
            d.pd_flag = 1'b1;
        end

        // sequencing
        if (q.state != whr_pkg::ST_STARTUP) begin
            d.start_cnt = 10'h000;
        end
        if (reset_src) begin
            d.state      = whr_pkg::ST_RESET;
            d.from_reset = 1'b1;
        end else begin
            case (q.state)
                whr_pkg::ST_RESET: begin
                    d.state      = whr_pkg::ST_RUN;
                    d.from_reset = 1'b0;
                end
                whr_pkg::ST_STARTUP: begin
                    d.start_cnt = q.start_cnt + 10'h001;
                    if (q.start_cnt == START_LAST) begin
                        d.state      = whr_pkg::ST_RUN;
                        d.from_reset = 1'b0;
                    end
                end
                whr_pkg::ST_RUN: begin
                    if (overflow) begin
                        d.state      = whr_pkg::ST_RESET;
                        d.from_reset = 1'b1;
                    end else if (sleep_cmd) begin
                        d.state = whr_pkg::ST_SLEEP;
                    end
                end
                whr_pkg::ST_SLEEP: begin
                    // oscillator restarts either way, so both paths wait it out
                    if (overflow) begin
                        d.state      = whr_pkg::ST_STARTUP;
                        d.from_reset = 1'b1;
                    end else if (wake) begin
                        d.state      = whr_pkg::ST_STARTUP;
                        d.from_reset = 1'b0;
                    end
                end
                default: begin
                    d.state      = whr_pkg::ST_RESET;
                    d.from_reset = 1'b1;
                end
            endcase
        end

        // apb: one wait state, answer on second access cycle
        acc     = apb_in.psel && apb_in.penable;
        addr_ok = (apb_in.paddr == whr_pkg::ADDR_CONFIG)
               || (apb_in.paddr == whr_pkg::ADDR_STATUS)
               || (apb_in.paddr == whr_pkg::ADDR_WAKE_EN)
               || (apb_in.paddr == whr_pkg::ADDR_STATE);
        rdata   = 32'h0000_0000;
        case (apb_in.paddr)
            whr_pkg::ADDR_CONFIG: begin
                rdata[5:0] = q.cfg;
            end
            whr_pkg::ADDR_STATUS: begin
                rdata[whr_pkg::STAT_PD_BIT] = q.pd_flag;
                rdata[whr_pkg::STAT_TO_BIT] = q.to_flag;
            end
            whr_pkg::ADDR_WAKE_EN: begin
                rdata[7:0] = q.wake_en;
            end
            whr_pkg::ADDR_STATE: begin
                rdata[1:0] = q.state;
                rdata[2]   = q.from_reset;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
        d.pready  = acc && !q.pready;
        d.pslverr = acc && !q.pready && !addr_ok;
        if (acc && !q.pready) begin
            d.prdata = apb_in.pwrite ? 32'h0000_0000 : rdata;
        end
        // status writes are accepted and dropped, flags untouched
        if (acc && q.pready && apb_in.pwrite) begin
            if (apb_in.paddr == whr_pkg::ADDR_CONFIG) begin
                d.cfg = apb_in.pwdata[5:0];
            end
            if (apb_in.paddr == whr_pkg::ADDR_WAKE_EN) begin
                d.wake_en = apb_in.pwdata[7:0];
            end
        end

        // registered outputs derived from the next state
        d.chip_reset = (d.state == whr_pkg::ST_RESET)
                    || ((d.state == whr_pkg::ST_STARTUP) && d.from_reset);
        d.core_run   = (d.state == whr_pkg::ST_RUN);
        d.osc_run    = (d.state != whr_pkg::ST_SLEEP);
        d.io_hold    = (d.state == whr_pkg::ST_SLEEP);
        d.io_input   = d.chip_reset;
        if (d.chip_reset) begin
            d.carr_o  = 1'b0;
            d.carr_oe = !d.cfg.carrier_nmos;
        end else if (d.cfg.carrier_nmos) begin
            d.carr_o  = 1'b0;
            d.carr_oe = carrier_in;
        end else begin
            d.carr_o  = carrier_in;
            d.carr_oe = 1'b1;
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    // power-on: flags 00, start-up delay inside the reset period
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q            <= '0;
            q.state      <= whr_pkg::ST_STARTUP;
            q.from_reset <= 1'b1;
            q.cfg        <= whr_pkg::CFG_RESET;
            q.wake_en    <= whr_pkg::WAKE_EN_RESET;
            q.to_flag    <= 1'b0;
            q.pd_flag    <= 1'b0;
            q.wake_prev  <= 8'hFF;
            q.chip_reset <= 1'b1;
            q.osc_run    <= 1'b1;
            q.io_input   <= 1'b1;
            q.carr_oe    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign pready_out         = q.pready;
    assign prdata_out         = q.prdata;
    assign pslverr_out        = q.pslverr;
    assign chip_reset_out     = q.chip_reset;
    assign pc_reset_value_out = whr_pkg::PC_RESET;
    assign core_run_out       = q.core_run;
    assign sys_osc_run_out    = q.osc_run;
    assign io_hold_out        = q.io_hold;
    assign io_input_mode_out  = q.io_input;
    assign carrier_pin_out    = q.carr_o;
    assign carrier_pin_oe_out = q.carr_oe;

endmodule // whr_top

`default_nettype wire

//--- tb/whr_properties.sv
// Purpose: port-level checks of whr_top
// Assumes: rstn_in is the only reset of the one clock domain
// Notes:   only ports are watched, so body changes need no edits here
`timescale 1ns/10ps
`default_nettype none

module whr_properties #(
    parameter int unsigned RC_DIV_CYCLES = 8
) (
    // clock and reset
    input wire logic                   clk_in,
    input wire logic                   rstn_in,
    // inputs seen
    input wire whr_pkg::whr_core_cmd_t core_cmd_in,
    input wire logic                   external_reset_pin_n_in,
    input wire logic                   low_voltage_reset_in,
    // outputs seen
    input wire logic                   chip_reset_out,
    input wire logic [9:0]             pc_reset_value_out,
    input wire logic                   core_run_out,
    input wire logic                   sys_osc_run_out,
    input wire logic                   io_hold_out,
    input wire logic                   io_input_mode_out,
    input wire logic                   carrier_pin_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // ************************************************
    // sleep steps
    // ************************************************
    // external pin quiet, so no pin reset competes with the strobe; low voltage and watchdog resets are not excluded
    sequence s_sleep_taken;
        core_run_out && core_cmd_in.sleep && !chip_reset_out && external_reset_pin_n_in;
    endsequence
    sequence s_asleep;
        !core_run_out && io_hold_out && !sys_osc_run_out;
    endsequence

    // ************************************************
    // assertions
    // ************************************************
    a_sleep_entry: assert property (s_sleep_taken |=> s_asleep)
        else $error("sleep not entered");
    a_wake_delay: assert property ($fell(io_hold_out) |-> !core_run_out [*8])
        else $error("core ran without start-up delay");
    a_run_awake: assert property (core_run_out |-> sys_osc_run_out && !io_hold_out)
        else $error("core runs while asleep");
    a_pin_reset: assert property (!external_reset_pin_n_in |=> chip_reset_out)
        else $error("pin reset missed");
    a_lvr_reset: assert property (low_voltage_reset_in |=> chip_reset_out)
        else $error("low voltage reset missed");
    a_reset_halts: assert property (chip_reset_out |-> !core_run_out && io_input_mode_out)
        else $error("core runs or ports driven in reset");
    a_pc_zero: assert property (pc_reset_value_out == 10'h000)
        else $error("pc reset value not zero");
    a_carrier_low: assert property (chip_reset_out |-> !carrier_pin_out)
        else $error("carrier pin high in reset");
endmodule // whr_properties

bind whr_top whr_properties #(.RC_DIV_CYCLES(RC_DIV_CYCLES)) i_props (
    .clk_in, .rstn_in, .core_cmd_in, .external_reset_pin_n_in, .low_voltage_reset_in,
    .chip_reset_out, .pc_reset_value_out, .core_run_out, .sys_osc_run_out, .io_hold_out,
    .io_input_mode_out, .carrier_pin_out);

`default_nettype wire

//--- tb/whr_core_model.sv
// Purpose: behavioural core issuing watchdog clear and sleep strobes
// Assumes: strobes are one-cycle pulses on clk_in
// Notes:   a held core executes nothing, so strobes wait for run
`timescale 1ns/10ps
`default_nettype none

module whr_core_model (
    // clock and run permission
    input  wire logic                   clk_in,
    input  wire logic                   core_run_in,
    // instruction strobes
    output var  whr_pkg::whr_core_cmd_t cmd_out
);
    initial cmd_out = '0;

    // one instruction, once the core runs
    task automatic issue(input whr_pkg::whr_core_cmd_t c);
        int n;
        n = 0;
        while (core_run_in !== 1'b1 && n < 4000) begin
            @(posedge clk_in);
            if (++n == 4000) whr_top_test.n_mismatch++;
        end
        @(posedge clk_in);
        cmd_out <= c;
        @(posedge clk_in);
        cmd_out <= '0;
    endtask

    // dual-clear software sends both halves
    task automatic clear_pair();
        issue(4'h4);
        issue(4'h2);
    endtask
endmodule // whr_core_model

`default_nettype wire

//--- tb/whr_top_test.sv
// Purpose: self-checking bench for whr_top
// Assumes: rc divider shortened to 8 clocks to keep runs short
// Notes:   core model issues clear and sleep strobes
`timescale 1ns/10ps
`default_nettype none

module whr_top_test;
    localparam int RCDIV = 8;
    // stimulus and observed signals
    logic                   clk_in = 1'b0;
    logic                   rstn_in = 1'b0;
    logic                   ext_n = 1'b1;
    logic                   low_voltage_reset = 1'b0;
    logic [7:0]             wake = 8'hFF;
    whr_pkg::whr_apb_req_t  apb = '0;
    whr_pkg::whr_core_cmd_t cmd;
    logic                   rdy, err, crst, run, osc, hold, cpin, coe, iom, car = 1'b1;
    logic [31:0]            rdata;
    logic [32:0]            q;
    int                     n_mismatch = 0;
    int                     checks = 0;
    int                     nres = 0;
    int                     n, m;
    // clear styles: config, pair strobes, reset expected
    logic [31:0]            tcfg [5] = '{32'h01, 32'h01, 32'h11, 32'h11, 32'h00};
    bit                     tpair [5] = '{0, 1, 0, 1, 1};
    bit                     texp [5] = '{0, 1, 1, 0, 0};

    whr_top #(.RC_DIV_CYCLES(RCDIV)) i_dut (
        .clk_in, .rstn_in, .apb_in(apb), .pready_out(rdy), .prdata_out(rdata),
        .pslverr_out(err), .core_cmd_in(cmd), .external_reset_pin_n_in(ext_n),
        .low_voltage_reset_in(low_voltage_reset), .wake_port_in(wake), .carrier_in(car),
        .chip_reset_out(crst), .pc_reset_value_out(), .core_run_out(run),
        .sys_osc_run_out(osc), .io_hold_out(hold), .io_input_mode_out(iom),
        .carrier_pin_out(cpin), .carrier_pin_oe_out(coe));
    whr_core_model i_core (.clk_in, .core_run_in(run), .cmd_out(cmd));

    always #2.5 clk_in = ~clk_in;
    // cycles spent in chip reset, to spot unwanted resets
    always @(posedge clk_in) if (crst === 1'b1) nres <= nres + 1;

    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string s, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", s, exp, seen);
        end
    endtask

    task automatic near(input string s, input int c, input int e, input int tol);
        chk(s, 33'(c >= e - tol && c <= e + tol), 33'h1);
    endtask

    // apb transfer; result is {error, data}
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [32:0] r);
        int k;
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        r = {err, rdata};
        apb <= '0;
        @(posedge clk_in);
        if (k >= 20) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
        logic [32:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(s, r, {1'b0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        xfer(1'b1, a, d, r);
    endtask

    // bounded wait for chip reset (sel) or run to reach lvl
    task automatic wait_on(input bit sel, input logic lvl, output int c);
        c = 0;
        while ((sel ? crst : run) !== lvl) begin
            @(posedge clk_in);
            c++;
            if (c > 20000) begin
                n_mismatch++;
                give_verdict();
            end
        end
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (12) @(posedge clk_in);
        chk("pins in reset", {crst, iom, cpin, coe}, 33'hD);
        rstn_in <= 1'b1;
        wait_on(0, 1'b1, n);
        near("startup", n, 1024, 3);
        rd(whr_pkg::ADDR_STATUS, 32'h0, "status power on");
        for (int k = 0; k < 4; k++) begin
            wr(whr_pkg::ADDR_CONFIG, 32'((k << 2) | ((k % 2) << 1) | 1));
            i_core.issue(4'h8);
            wait_on(1, 1'b1, n);
            near("wdt period", n, (1 << (8 + k)) * (k % 2 ? RCDIV : 4), 16);
            rd(whr_pkg::ADDR_STATUS, 32'h20, "status wdt");
            wait_on(0, 1'b1, n);
        end
        wr(whr_pkg::ADDR_STATUS, 32'h0);
        rd(whr_pkg::ADDR_STATUS, 32'h20, "status write");
        for (int t = 0; t < 5; t++) begin
            wr(whr_pkg::ADDR_CONFIG, tcfg[t]);
            for (int r = 0; r < 5; r++) begin
                if (r == 1) m = nres;
                if (tpair[t]) i_core.clear_pair();
                else i_core.issue(4'h8);
                repeat (600) @(posedge clk_in);
            end
            chk("clear style", 33'(nres != m), 33'(texp[t]));
        end
        wr(whr_pkg::ADDR_CONFIG, 32'h01);
        wr(whr_pkg::ADDR_WAKE_EN, 32'h04);
        i_core.issue(4'h8);
        i_core.issue(4'h1);
        @(posedge clk_in);
        chk("sleep outputs", {run, hold, osc, cpin}, 33'h5);
        rd(whr_pkg::ADDR_STATUS, 32'h10, "status sleep");
        wake <= 8'hFD;
        car <= 1'b0;
        repeat (2000) @(posedge clk_in);
        chk("masked pin", {hold, crst, cpin}, 33'h4);
        m = nres;
        wake <= 8'hF9;
        wait_on(0, 1'b1, n);
        near("wake delay", n, 1024, 6);
        chk("wake no reset", nres, m);
        wake <= 8'hFF;
        i_core.issue(4'h8);
        rd(whr_pkg::ADDR_STATUS, 32'h0, "status clear");
        // rc source keeps the watchdog alive in sleep
        wr(whr_pkg::ADDR_CONFIG, 32'h03);
        i_core.issue(4'h8);
        i_core.issue(4'h1);
        wait_on(1, 1'b1, n);
        near("sleep wdt", n, 2048, 16);
        wait_on(0, 1'b1, n);
        near("sleep wdt startup", n, 1024, 4);
        rd(whr_pkg::ADDR_STATUS, 32'h30, "status sleep wdt");
        wr(whr_pkg::ADDR_CONFIG, 32'h20);
        ext_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("pin reset", {crst, cpin, coe}, 33'h4);
        ext_n <= 1'b1;
        wait_on(0, 1'b1, n);
        low_voltage_reset <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("lvr reset", crst, 33'h1);
        low_voltage_reset <= 1'b0;
        wait_on(0, 1'b1, n);
        rd(whr_pkg::ADDR_STATUS, 32'h30, "status pin");
        rstn_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        wait_on(0, 1'b1, n);
        rd(whr_pkg::ADDR_STATUS, 32'h0, "status power on again");
        xfer(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", q, 33'h1_0000_0000);
        give_verdict();
    end
endmodule // whr_top_test

`default_nettype wire
